//--- core/spi_stack_pkg.sv
// constants and types shared by the stacked-die serial front end
// Overview of operation
// - die zero active after power-up
// - C2H plus 8-bit id picks active die
// - at most one die drives the bus
// - idle die hears only C2H, 66H/99H
// - idle die keeps running its program/erase
// - die select never aborts program/erase
// - 66H then 99H resets every die
// - works in SPI mode 0 and 3
// - sample on rising, shift on falling
// - dual reads use IO0 and IO1
// - quad reads use IO0 to IO3
// - quad enable fixed at one
// - EDH/EEH move data on both edges
// - ECC off keeps event pin released
// - pin low over flagged 8-byte group
// - select bit picks correction or detection
// - event pin is open-drain
// - ECC groups are aligned 8-byte groups
package spi_stack_pkg;
    localparam logic [7:0] OP_DIE_SELECT   = 8'hc2;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET        = 8'h99;
    localparam logic [7:0] DIE_ID0_DEFAULT = 8'h00;
    localparam logic [7:0] DIE_ID1_DEFAULT = 8'h01;
    localparam logic [1:0] ACTIVE_RESET    = 2'h1;
    localparam logic       QUAD_ENABLE_VAL = 1'b1;
    localparam logic [3:0] DUMMY_FAST      = 4'h8;
    localparam logic [3:0] DUMMY_QUAD_IO   = 4'h6;
    localparam logic [3:0] DUMMY_NONE      = 4'h0;
    localparam logic [7:0] IDLE_FILL       = 8'hff;
    localparam int         FIFO_DEPTH      = 8;
    localparam int         FIFO_WIDTH      = 10;

    typedef enum logic [4:0] {
        S_CMD    = 5'h01,
        S_ID     = 5'h02,
        S_ADDR   = 5'h04,
        S_DUMMY  = 5'h08,
        S_DATA   = 5'h10
    } frame_state_t;
endpackage

//--- core/read_fifo_if.sv
// handshake bundle between the read data buffer and the serial shifter
`timescale 1ns/10ps
`default_nettype none
interface read_fifo_if #(parameter int WIDTH = 10);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic             flush;

    modport buffer   (input push_valid, push_data, pop_ready, flush,
                      output push_ready, pop_valid, pop_data);
    modport producer (output push_valid, push_data,
                      input push_ready);
    modport consumer (output pop_ready, flush,
                      input pop_valid, pop_data);
endinterface
`default_nettype wire

//--- core/read_fifo.sv
// small read data buffer between the array side and the serial shifter
`timescale 1ns/10ps
`default_nettype none
module read_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    read_fifo_if.buffer f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             do_push;
    logic             do_pop;

    assign f.push_ready = (count_q != (AW+1)'(DEPTH)) && !f.flush;
    assign f.pop_valid  = (count_q != '0) && !f.flush;
    assign f.pop_data   = mem_q[rd_ptr_q];
    assign do_push      = f.push_valid && f.push_ready;
    assign do_pop       = f.pop_valid && f.pop_ready;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= f.push_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (f.flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

//--- core/stacked_die_spi_flash_front_end.sv
// serial bus front end shared by two stacked flash dies
`timescale 1ns/10ps
`default_nettype none
module stacked_die_spi_flash_front_end #(
    parameter logic [7:0] DIE_ID0 = spi_stack_pkg::DIE_ID0_DEFAULT,
    parameter logic [7:0] DIE_ID1 = spi_stack_pkg::DIE_ID1_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe,
    output logic             ecc_event_out_n_o,
    output logic             ecc_event_out_n_oe,
    input  wire logic        ecc_enable,
    input  wire logic        ecc_pin_report_select,
    output logic             quad_lines_enable,
    output logic      [1:0]  active_die,
    output logic             sw_reset,
    output logic             cmd_valid,
    output logic      [7:0]  cmd_opcode,
    output logic             rd_req,
    output logic      [31:0] rd_addr,
    output logic             rd_die,
    output logic             frame_end,
    input  wire logic        rd_data_valid,
    input  wire logic [7:0]  rd_data,
    input  wire logic        rd_data_sec,
    input  wire logic        rd_data_ded,
    output logic             rd_data_ready
);
    // reset release
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // pins come from the host domain: two flops before use
    logic       sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic       cs_s1_q, cs_s2_q, cs_s3_q;
    logic [3:0] io_s1_q, io_s2_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            cs_s3_q   <= 1'b1;
            io_s1_q   <= 4'h0;
            io_s2_q   <= 4'h0;
        end else begin
            sclk_s1_q <= sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q   <= cs_n;
            cs_s2_q   <= cs_s1_q;
            cs_s3_q   <= cs_s2_q;
            io_s1_q   <= io_i;
            io_s2_q   <= io_s1_q;
        end
    end

    // only edges are used, so idle level of the clock (mode 0 or 3)
    // does not matter; data pins are sampled with the same delay
    logic sel;
    logic rise;
    logic fall;
    assign sel  = !cs_s2_q;
    assign rise = sel && sclk_s2_q && !sclk_s3_q;
    assign fall = sel && !sclk_s2_q && sclk_s3_q;

    assign quad_lines_enable = spi_stack_pkg::QUAD_ENABLE_VAL;

    // command classes: {read, addr lanes, data lanes, dtr, 4-byte, dummy}
    function automatic logic is_read(input logic [7:0] op);
        case (op)
            8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c,
            8'hbb, 8'hbc, 8'heb, 8'hec, 8'hed, 8'hee: is_read = 1'b1;
            default: is_read = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] addr_lanes(input logic [7:0] op);
        case (op)
            8'hbb, 8'hbc: addr_lanes = 3'h2;
            8'heb, 8'hec, 8'hed, 8'hee: addr_lanes = 3'h4;
            default: addr_lanes = 3'h1;
        endcase
    endfunction

    function automatic logic [2:0] data_lanes(input logic [7:0] op);
        case (op)
            8'h3b, 8'h3c, 8'hbb, 8'hbc: data_lanes = 3'h2;
            8'h6b, 8'h6c, 8'heb, 8'hec,
            8'hed, 8'hee: data_lanes = 3'h4;
            default: data_lanes = 3'h1;
        endcase
    endfunction

    function automatic logic [3:0] dummy_of(input logic [7:0] op);
        case (op)
            8'h03, 8'h13: dummy_of = spi_stack_pkg::DUMMY_NONE;
            8'heb, 8'hec: dummy_of = spi_stack_pkg::DUMMY_QUAD_IO;
            default: dummy_of = spi_stack_pkg::DUMMY_FAST;
        endcase
    endfunction

    spi_stack_pkg::frame_state_t state_q;
    logic [2:0]  lanes_q;
    logic [2:0]  data_lanes_q;
    logic        dtr_q;
    logic [2:0]  addr_left_q;
    logic [3:0]  dummy_q;
    logic [3:0]  bitcnt_q;
    logic [7:0]  shin_q;
    logic [1:0]  active_q;
    logic        reset_armed_q;

    // input shifter: one, two or four bits per sampling edge
    logic       in_edge;
    logic [7:0] shin_d;
    logic [3:0] bitcnt_d;
    logic       byte_done;
    assign in_edge = rise || (dtr_q && fall && state_q == spi_stack_pkg::S_ADDR);

    always_comb begin
        shin_d   = shin_q;
        bitcnt_d = bitcnt_q + 4'(lanes_q);
        case (lanes_q)
            3'h2:    shin_d = {shin_q[5:0], io_s2_q[1:0]};
            3'h4:    shin_d = {shin_q[3:0], io_s2_q[3:0]};
            default: shin_d = {shin_q[6:0], io_s2_q[0]};
        endcase
    end
    assign byte_done = in_edge && bitcnt_d == 4'h8 &&
                       state_q != spi_stack_pkg::S_DUMMY &&
                       state_q != spi_stack_pkg::S_DATA;

    logic any_active;
    logic cmd_byte;
    logic die_sel_ev;
    logic reset_ev;
    logic read_ev;
    logic other_ev;
    assign any_active = |active_q;
    assign cmd_byte   = byte_done && state_q == spi_stack_pkg::S_CMD;
    assign die_sel_ev = byte_done && state_q == spi_stack_pkg::S_ID;
    assign reset_ev   = cmd_byte && shin_d == spi_stack_pkg::OP_RESET &&
                        reset_armed_q;
    // an idle stack hears only select and reset
    assign read_ev    = cmd_byte && any_active && is_read(shin_d);
    assign other_ev   = cmd_byte && any_active && !is_read(shin_d) &&
                        shin_d != spi_stack_pkg::OP_DIE_SELECT &&
                        shin_d != spi_stack_pkg::OP_RESET_ENABLE &&
                        !reset_ev;

    // frame sequencing; anything not understood waits out the frame
    logic in_frame_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q      <= spi_stack_pkg::S_CMD;
            in_frame_q   <= 1'b0;
            lanes_q      <= 3'h1;
            data_lanes_q <= 3'h1;
            dtr_q        <= 1'b0;
            addr_left_q  <= 3'h0;
            dummy_q      <= 4'h0;
            bitcnt_q     <= 4'h0;
            shin_q       <= 8'h00;
        end else if (!sel) begin
            state_q    <= spi_stack_pkg::S_CMD;
            in_frame_q <= 1'b1;
            lanes_q    <= 3'h1;
            dtr_q      <= 1'b0;
            bitcnt_q   <= 4'h0;
        end else if (in_edge && in_frame_q) begin
            shin_q   <= shin_d;
            bitcnt_q <= (bitcnt_d == 4'h8) ? 4'h0 : bitcnt_d;
            case (state_q)
                spi_stack_pkg::S_CMD: begin
                    if (bitcnt_d == 4'h8) begin
                        in_frame_q <= shin_d == spi_stack_pkg::OP_DIE_SELECT
                                      || read_ev;
                        if (shin_d == spi_stack_pkg::OP_DIE_SELECT) begin
                            state_q <= spi_stack_pkg::S_ID;
                        end
                        if (read_ev) begin
                            state_q      <= spi_stack_pkg::S_ADDR;
                            lanes_q      <= addr_lanes(shin_d);
                            data_lanes_q <= data_lanes(shin_d);
                            dtr_q        <= shin_d == 8'hed ||
                                            shin_d == 8'hee;
                            addr_left_q  <= (shin_d[3:0] == 4'hc ||
                                             shin_d == 8'h13 ||
                                             shin_d == 8'hee) ? 3'h4 : 3'h3;
                            dummy_q      <= dummy_of(shin_d);
                        end
                    end
                end
                spi_stack_pkg::S_ID: begin
                    if (bitcnt_d == 4'h8) begin
                        in_frame_q <= 1'b0;
                    end
                end
                spi_stack_pkg::S_ADDR: begin
                    if (bitcnt_d == 4'h8) begin
                        addr_left_q <= addr_left_q - 3'h1;
                        if (addr_left_q == 3'h1) begin
                            state_q <= (dummy_q == 4'h0) ?
                                       spi_stack_pkg::S_DATA :
                                       spi_stack_pkg::S_DUMMY;
                        end
                    end
                end
                spi_stack_pkg::S_DUMMY: begin
                    // dummy counts clocks, so only rising edges count
                    if (rise) begin
                        dummy_q <= dummy_q - 4'h1;
                        if (dummy_q == 4'h1) begin
                            state_q <= spi_stack_pkg::S_DATA;
                        end
                    end
                end
                spi_stack_pkg::S_DATA: begin
                    bitcnt_q <= 4'h0;
                end
                default: begin
                    state_q <= spi_stack_pkg::S_CMD;
                end
            endcase
        end
    end

    // die activity: a die follows its own id, reset brings back die zero
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            active_q <= spi_stack_pkg::ACTIVE_RESET;
        end else if (reset_ev) begin
            active_q <= spi_stack_pkg::ACTIVE_RESET;
        end else if (die_sel_ev) begin
            // ids differ, so at most one bit can be set
            active_q <= {shin_d == DIE_ID1,
                         shin_d == DIE_ID0};
        end
    end
    assign active_die = active_q;

    // reset arm lives across frames and dies on any other instruction
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reset_armed_q <= 1'b0;
        end else if (cmd_byte) begin
            reset_armed_q <= shin_d == spi_stack_pkg::OP_RESET_ENABLE;
        end
    end

    // requests toward the array; die select emits nothing here, so a
    // running program or erase on either die is never disturbed
    logic [31:0] addr_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sw_reset   <= 1'b0;
            cmd_valid  <= 1'b0;
            cmd_opcode <= 8'h00;
            rd_req     <= 1'b0;
            rd_addr    <= 32'h0;
            rd_die     <= 1'b0;
            addr_q     <= 32'h0;
            frame_end  <= 1'b0;
        end else begin
            sw_reset  <= reset_ev;
            cmd_valid <= other_ev;
            rd_req    <= 1'b0;
            frame_end <= sel == 1'b0 && cs_s3_q == 1'b0;
            if (other_ev || read_ev) begin
                cmd_opcode <= shin_d;
                rd_die     <= active_q[1];
                addr_q     <= 32'h0;
            end
            if (byte_done && state_q == spi_stack_pkg::S_ADDR) begin
                addr_q <= {addr_q[23:0], shin_d};
                if (addr_left_q == 3'h1) begin
                    rd_req  <= 1'b1;
                    rd_addr <= {addr_q[23:0], shin_d};
                end
            end
        end
    end

    // read data buffer: array pushes {ded, sec, byte}
    read_fifo_if #(.WIDTH(spi_stack_pkg::FIFO_WIDTH)) rbuf ();
    assign rbuf.push_valid = rd_data_valid;
    assign rbuf.push_data  = {rd_data_ded, rd_data_sec, rd_data};
    assign rd_data_ready   = rbuf.push_ready;
    assign rbuf.flush      = !sel;

    read_fifo #(
        .WIDTH (spi_stack_pkg::FIFO_WIDTH),
        .DEPTH (spi_stack_pkg::FIFO_DEPTH)
    ) u_read_fifo (
        .clk   (clk),
        .rst_n (rst_n_q),
        .f     (rbuf)
    );

    // output shifter: launch on falling edge, both edges for dtr
    logic       out_edge;
    logic       load;
    logic [7:0] out_sh_q;
    logic [3:0] out_cnt_q;
    logic [7:0] next_byte;
    logic [7:0] cur;
    logic       byte_flag_q;
    logic       next_flag;
    logic       data_phase;
    assign data_phase = state_q == spi_stack_pkg::S_DATA && any_active;
    assign out_edge   = data_phase && (fall || (dtr_q && rise));
    assign load       = out_edge && out_cnt_q == 4'h0;
    // an empty buffer sends erased data rather than stalling the host
    assign rbuf.pop_ready = load;
    assign next_byte  = rbuf.pop_valid ? rbuf.pop_data[7:0] :
                        spi_stack_pkg::IDLE_FILL;
    assign next_flag  = rbuf.pop_valid &&
                        (ecc_pin_report_select ? rbuf.pop_data[9] :
                                                 rbuf.pop_data[8]);
    assign cur        = load ? next_byte : out_sh_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            io_o        <= 4'h0;
            io_oe       <= 4'h0;
            out_sh_q    <= 8'h00;
            out_cnt_q   <= 4'h0;
            byte_flag_q <= 1'b0;
        end else if (!data_phase) begin
            io_oe     <= 4'h0;
            out_cnt_q <= 4'h0;
            byte_flag_q <= 1'b0;
        end else if (out_edge) begin
            if (load) begin
                byte_flag_q <= next_flag;
            end
            case (data_lanes_q)
                3'h2: begin
                    io_o     <= {2'b00, cur[7:6]};
                    io_oe    <= 4'h3;
                    out_sh_q <= {cur[5:0], 2'b00};
                end
                3'h4: begin
                    io_o     <= cur[7:4];
                    io_oe    <= 4'hf;
                    out_sh_q <= {cur[3:0], 4'h0};
                end
                default: begin
                    io_o     <= {2'b00, cur[7], 1'b0};
                    io_oe    <= 4'h2;
                    out_sh_q <= {cur[6:0], 1'b0};
                end
            endcase
            out_cnt_q <= (load ? 4'h8 : out_cnt_q) - 4'(data_lanes_q);
        end
    end

    // event pin: only ever pulls low, follows the flag of each byte sent;
    // the array flags every byte of an aligned 8-byte group alike
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ecc_event_out_n_oe <= 1'b0;
        end else begin
            ecc_event_out_n_oe <= ecc_enable && data_phase &&
                                  (load ? next_flag : byte_flag_q)
                                  && (out_edge || io_oe != 4'h0);
        end
    end
    assign ecc_event_out_n_o = 1'b0;
endmodule
`default_nettype wire

//--- verification/spi_stack_props.sv
// pin-level assertions for the stacked die front end
`timescale 1ns/10ps
`default_nettype none
module spi_stack_props (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       cs_n,
    input wire logic [3:0] io_oe,
    input wire logic       ecc_event_out_n_o,
    input wire logic       ecc_event_out_n_oe,
    input wire logic       ecc_enable,
    input wire logic       quad_lines_enable,
    input wire logic [1:0] active_die,
    input wire logic       sw_reset,
    input wire logic       rd_req
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_ONE_DIE: assert property ($onehot0(active_die))
        else $error("two dies active");
    AST_IDLE_MUTE: assert property (active_die == 2'h0 &&
        $past(active_die) == 2'h0 |-> io_oe == 4'h0 && !rd_req)
        else $error("idle stack answered");
    AST_RESET_DIE0: assert property (
        sw_reset |-> ##[0:4] active_die == 2'h1)
        else $error("reset left die zero idle");
    AST_QUAD_ON: assert property (quad_lines_enable == 1'b1)
        else $error("quad enable low");
    AST_ECC_OFF: assert property (
        !ecc_enable [*3] |-> !ecc_event_out_n_oe)
        else $error("event pin pulled with ecc off");
    AST_ECC_OD: assert property (ecc_event_out_n_o == 1'b0)
        else $error("event pin driven high");
    AST_LANES: assert property (
        io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("bad lane enable set");
    // sync plus output register needs a few cycles after deselect
    AST_DESELECT: assert property (
        cs_n [*6] |-> io_oe == 4'h0 && !ecc_event_out_n_oe)
        else $error("driving while deselected");
endmodule
bind stacked_die_spi_flash_front_end spi_stack_props i_props (
    .clk(clk), .resetn(resetn), .cs_n(cs_n), .io_oe(io_oe),
    .ecc_event_out_n_o(ecc_event_out_n_o),
    .ecc_event_out_n_oe(ecc_event_out_n_oe), .ecc_enable(ecc_enable),
    .quad_lines_enable(quad_lines_enable), .active_die(active_die),
    .sw_reset(sw_reset), .rd_req(rd_req)
);
`default_nettype wire

//--- verification/spi_host_model.sv
// serial host model on the shared bus, mode 0 or mode 3
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    output logic            sclk,
    output logic            cs_n,
    output logic      [3:0] io_drv,
    input  wire logic [3:0] io_pin
);
    logic idle_lvl;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_drv = 4'h0;
        idle_lvl = 1'b0;
    end
    // released lanes toggle so a stale value never passes for data
    task automatic tick(input logic [3:0] v, input logic [3:0] en,
                        output logic [3:0] s);
        sclk = 1'b0;
        io_drv = (v & en) | (~io_drv & ~en);
        #40 sclk = 1'b1;
        #39 s = io_pin;
        #1;
    endtask
    task automatic open_f(input logic mode3);
        idle_lvl = mode3;
        sclk = mode3;
        #40 cs_n = 1'b0;
        #40;
    endtask
    task automatic close_f;
        #40 sclk = idle_lvl;
        #40 cs_n = 1'b1;
        io_drv = ~io_drv;
        #400;
    endtask
    task automatic put(input logic [7:0] b);
        logic [3:0] s;
        for (int i = 7; i >= 0; i--) begin
            tick({3'h0, b[i]}, 4'h1, s);
        end
    endtask
    // late sample: the device answers a few clocks after each fall
    task automatic get(input int lanes, input int skip,
                       output logic [7:0] b);
        logic [3:0] s;
        logic [3:0] m;
        b = 8'h00;
        m = (lanes == 4) ? 4'hf : 4'h3;
        repeat (skip) tick(4'h0, 4'h0, s);
        for (int i = 0; i < 8 / lanes; i++) begin
            tick(4'h0, 4'h0, s);
            b = (b << lanes) | (lanes == 1 ? {7'h0, s[1]} : {4'h0, s & m});
        end
    endtask
endmodule
`default_nettype wire

//--- verification/stacked_die_spi_flash_front_end_tb.sv
// self-checking bench for the stacked die front end
`timescale 1ns/10ps
`default_nettype none
module stacked_die_spi_flash_front_end_tb;
    logic        clk, resetn, sclk, cs_n, ecc_o, ecc_oe, ecc_pin, quad_en;
    logic        ecc_enable, ecc_sel, sw_reset, cmd_valid, rd_req, rd_sec;
    logic        rd_ded, rd_data_valid, rd_data_ready, rd_die, frame_end;
    logic [3:0]  io_i, io_o, io_oe, io_drv;
    logic [1:0]  active_die;
    logic [7:0]  cmd_opcode, rd_data, last_cmd, b, d0;
    logic [31:0] rd_addr, req_addr;
    int          req_n = 0, n0 = 0, err_total = 0, compares = 0;
    int          rst_cnt = 0, ecc_cnt = 0, e0 = 0, fe_n = 0;
    logic [7:0]  op [4] = '{8'h03, 8'h3b, 8'h6b, 8'heb};
    logic [3:0]  oex [4] = '{4'h2, 4'h3, 4'hf, 4'hf};
    int          lanes [4] = '{1, 2, 4, 4};
    // dummy clocks per case: none, fast, fast, quad address
    int          skip [4] = '{0, 8, 8, 6};
    // bit i per case: ecc on, single flag, double flag, report double
    logic [3:0]  en = 4'he, sec = 4'h3, ded = 4'hc, sel = 4'h8;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    assign io_i = (io_oe & io_o) | (~io_oe & io_drv);
    assign ecc_pin = ecc_oe ? ecc_o : 1'b1;
    stacked_die_spi_flash_front_end i_dut (
        .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .io_i(io_i),
        .io_o(io_o), .io_oe(io_oe), .ecc_event_out_n_o(ecc_o),
        .ecc_event_out_n_oe(ecc_oe), .ecc_enable(ecc_enable),
        .ecc_pin_report_select(ecc_sel), .quad_lines_enable(quad_en),
        .active_die(active_die), .sw_reset(sw_reset), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_die(rd_die), .frame_end(frame_end),
        .rd_data_valid(rd_data_valid),
        .rd_data(rd_data), .rd_data_sec(rd_sec), .rd_data_ded(rd_ded),
        .rd_data_ready(rd_data_ready)
    );
    spi_host_model i_host (
        .sclk(sclk), .cs_n(cs_n), .io_drv(io_drv), .io_pin(io_i)
    );
    always @(posedge clk) begin
        if (rd_req) req_n <= req_n + 1;
        if (rd_req) req_addr <= rd_addr;
        if (cmd_valid) last_cmd <= cmd_opcode;
        if (sw_reset) rst_cnt <= rst_cnt + 1;
        if (ecc_pin === 1'b0) ecc_cnt <= ecc_cnt + 1;
        if (frame_end) fe_n <= fe_n + 1;
    end
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic push(input logic [7:0] d, input logic s, input logic e);
        @(posedge clk) #1;
        rd_data_valid = 1'b1;
        rd_data = d;
        rd_sec = s;
        rd_ded = e;
        while (rd_data_ready !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1;
        rd_data_valid = 1'b0;
    endtask
    // quad address: high nibble first, one nibble per rising edge
    task automatic put_addr(input logic quad, input logic [7:0] a);
        logic [3:0] s;
        if (quad) begin
            i_host.tick(a[7:4], 4'hf, s);
            i_host.tick(a[3:0], 4'hf, s);
        end else begin
            i_host.put(a);
        end
    endtask
    task automatic frame(input logic [7:0] a, input logic [7:0] d,
                         input int n);
        i_host.open_f(1'b0);
        i_host.put(a);
        repeat (n - 1) i_host.put(d);
        i_host.close_f();
    endtask
    task automatic final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        final_report();
    end
    initial begin
        {resetn, ecc_enable, ecc_sel, rd_data_valid, rd_sec, rd_ded} = 6'h0;
        rd_data = 8'h00;
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (8) @(posedge clk);
        chk("active_die", 32'h1, active_die);
        chk("quad_lines_enable", 32'h1, quad_en);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) #1;
            ecc_enable = en[i];
            ecc_sel = sel[i];
            e0 = ecc_cnt;
            n0 = req_n;
            d0 = 8'h40 + 8'(8 * i);
            i_host.open_f(i == 3);
            i_host.put(op[i]);
            put_addr(i == 3, 8'h00);
            put_addr(i == 3, 8'(i + 1));
            put_addr(i == 3, 8'h00);
            repeat (8) @(posedge clk);
            chk("rd_req", n0 + 1, req_n);
            chk("rd_addr", (i + 1) << 8, req_addr);
            for (int k = 0; k < 8; k++) begin
                push(d0 + 8'(k), sec[i], ded[i]);
            end
            chk("rd_data_ready", 32'h0, rd_data_ready);
            for (int k = 0; k < 9; k++) begin
                i_host.get(lanes[i], k == 0 ? skip[i] : 0, b);
                chk("rd_data", k < 8 ? d0 + 8'(k) : 8'hff, b);
                chk("io_oe", oex[i], io_oe);
            end
            chk("ecc_pin", en[i] & (sel[i] ? ded[i] : sec[i]),
                ecc_cnt != e0);
            i_host.close_f();
        end
        frame(8'hc2, 8'h01, 2);
        chk("active_die", 32'h2, active_die);
        frame(8'h06, 8'h00, 1);
        chk("cmd_opcode", 32'h06, last_cmd);
        chk("rd_die", 32'h1, rd_die);
        frame(8'hc2, 8'h07, 2);
        chk("active_die", 32'h0, active_die);
        n0 = req_n;
        frame(8'h03, 8'h00, 4);
        chk("rd_req", n0, req_n);
        frame(8'h99, 8'h00, 1);
        chk("sw_reset", 32'h0, rst_cnt);
        frame(8'h66, 8'h00, 1);
        frame(8'h99, 8'h00, 1);
        chk("sw_reset", 32'h1, rst_cnt);
        chk("active_die", 32'h1, active_die);
        chk("frame_end", 32'hb, fe_n);
        final_report();
    end
endmodule
`default_nettype wire
